// file: common/seeprm_pkg.sv
/*
 * Constants of the serial memory front end: fields, opcodes, counts, times.
 * Assumes a single 25 MHz system clock in the enclosing design.
 */
// Summary of operation
// - select low gives standby once any programming cycle has finished.
// - select low holds the decoding logic in reset.
// - bits are taken in and shifted out on serial clock rising edges.
// - the serial clock may pause at either level; transfer then resumes.
// - selected without a start bit, any clocks change nothing.
// - start bit: first rising edge with select and serial_in high.
// - an instruction executes only once all its bits are in.
// - after the last bit, inputs are ignored until select falls; then a new start bit is needed.
// - opcode 2 bits, address 6; opcode 00 takes a sub-command from the top two.
// - serial_out is off except for read data or status; off when select falls.
// - status after reselect shows low while programming, high when ready.
// - select low through a whole cycle leaves output off; later status reads high.
// - starts disabled; program_enable allows erase and writes until program_disable.
// - read works whether programming is enabled or not.
// - erase sets the addressed word to ones, from the last address edge.
// - erase_all sets the whole array to ones, from the last address edge.
// - self-timed cycles complete without any serial clocks.
// - read gives a dummy zero then 16 data bits, most significant first.
// - while selected, read goes on with the next word.
// - write takes 16 data bits, then self-timed erase and program of the word.
// - write_all erases then programs every word with the data; only when enabled.
package seeprm_pkg;

    localparam int unsigned SYS_CLK_HZ      = 25_000_000;
    localparam int unsigned ADDR_W          = 6;
    localparam int unsigned DATA_W          = 16;
    localparam int unsigned CMD_BITS        = 8;   // opcode plus address
    localparam int unsigned CMD_CNT_W       = 5;

    // opcodes
    localparam logic [1:0] OP_EXT           = 2'h0;
    localparam logic [1:0] OP_WRITE         = 2'h1;
    localparam logic [1:0] OP_READ          = 2'h2;
    localparam logic [1:0] OP_ERASE         = 2'h3;

    // sub-commands in the top two address bits under OP_EXT
    localparam logic [1:0] SUB_PROG_DIS     = 2'h0;
    localparam logic [1:0] SUB_WRITE_ALL    = 2'h1;
    localparam logic [1:0] SUB_ERASE_ALL    = 2'h2;
    localparam logic [1:0] SUB_PROG_EN      = 2'h3;

    localparam logic [DATA_W-1:0] ERASED_WORD = 16'hFFFF;

    // programming times in microseconds, then in system clock cycles
    localparam int unsigned T_WORD_US       = 2000;
    localparam int unsigned T_ERALL_US      = 6000;
    localparam int unsigned T_WRALL_US      = 15000;
    localparam int unsigned T_WORD_CYC      = T_WORD_US * (SYS_CLK_HZ / 1_000_000);
    localparam int unsigned T_ERALL_CYC     = T_ERALL_US * (SYS_CLK_HZ / 1_000_000);
    localparam int unsigned T_WRALL_CYC     = T_WRALL_US * (SYS_CLK_HZ / 1_000_000);

    typedef enum logic [2:0] {
        SEE_IDLE  = 3'b000,
        SEE_CMD   = 3'b001,
        SEE_WDATA = 3'b010,
        SEE_RDATA = 3'b011,
        SEE_DONE  = 3'b100
    } seeprm_state_t;

    typedef enum logic [1:0] {
        PRG_WORD  = 2'b00,
        PRG_ERALL = 2'b01,
        PRG_WRALL = 2'b10
    } seeprm_prg_t;

endpackage : seeprm_pkg

// file: core/seeprm_core.sv
/*
 * Serial memory command front end with a self-timed programming engine;
 * the 64 x 16 array is flip-flops.
 * Assumes select, clock and serial_in are pins, asynchronous to i_clk_sys.
 */
`timescale 1ns/10ps
`default_nettype none
module seeprm_core
    import seeprm_pkg::*;
#(
    parameter int unsigned WORD_CYC  = T_WORD_CYC,
    parameter int unsigned ERALL_CYC = T_ERALL_CYC,
    parameter int unsigned WRALL_CYC = T_WRALL_CYC,
    parameter int unsigned FIFO_DEPTH = 4
) (
    // clock and reset
    input  wire logic i_clk_sys,
    input  wire logic i_nrst,
    // serial link pins
    input  wire logic i_select,
    input  wire logic i_sclk,
    input  wire logic i_serial_in,
    // serial output pin
    output logic      o_serial_out,
    output logic      o_serial_out_oe,
    // status
    output logic      o_busy
);
    localparam int unsigned MAX_CYC = WRALL_CYC;
    localparam int unsigned TMR_W   = $clog2(MAX_CYC + 1);
    localparam int unsigned WORDS   = 1 << ADDR_W;

    initial begin
        if (WORD_CYC < 1 || ERALL_CYC < 1 || WRALL_CYC < ERALL_CYC || WRALL_CYC < WORD_CYC) begin
            $error("bad programming counts");
        end
    end

    ////////////////////////////////////////////////////////////////////
    // pin synchronisers

    logic sel_lvl;
    logic sclk_rise;
    logic din_lvl;

    seeprm_sync u_sync_sel (
        .i_clk_sys (i_clk_sys),
        .i_nrst    (i_nrst),
        .i_pin     (i_select),
        .o_level   (sel_lvl),
        .o_rise    (),
        .o_fall    ()
    );

    seeprm_sync u_sync_clk (
        .i_clk_sys (i_clk_sys),
        .i_nrst    (i_nrst),
        .i_pin     (i_sclk),
        .o_level   (),
        .o_rise    (sclk_rise),
        .o_fall    ()
    );

    seeprm_sync u_sync_din (
        .i_clk_sys (i_clk_sys),
        .i_nrst    (i_nrst),
        .i_pin     (i_serial_in),
        .o_level   (din_lvl),
        .o_rise    (),
        .o_fall    ()
    );

    // edges only count while selected; pauses simply add no edges
    logic bit_tick;
    assign bit_tick = sclk_rise && sel_lvl;

    ////////////////////////////////////////////////////////////////////
    // storage and protection

    logic [DATA_W-1:0] array_r [WORDS];
    logic              prog_en_r;

    ////////////////////////////////////////////////////////////////////
    // command shifter and state

    seeprm_state_t      state_r;
    logic [CMD_CNT_W-1:0] cnt_r;
    logic [CMD_BITS-1:0]  cmd_r;
    logic [DATA_W-1:0]    wdata_r;
    logic [ADDR_W-1:0]    raddr_r;
    logic [DATA_W-1:0]    rshift_r;
    logic [CMD_BITS-1:0]  cmd_full;
    logic [1:0]           opc;
    logic [1:0]           sub;

    assign cmd_full = {cmd_r[CMD_BITS-2:0], din_lvl};
    assign opc      = cmd_full[CMD_BITS-1 -: 2];
    assign sub      = cmd_full[ADDR_W-1 -: 2];

    // launch request from the decoder to the programming engine
    logic              launch;
    seeprm_prg_t       launch_kind;
    logic [ADDR_W-1:0] launch_addr;
    logic [DATA_W-1:0] launch_data;

    logic cmd_last;
    logic data_last;
    assign cmd_last  = (cnt_r == CMD_CNT_W'(CMD_BITS - 1));
    assign data_last = (cnt_r == CMD_CNT_W'(DATA_W - 1));

    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            state_r <= SEE_IDLE;
            cnt_r   <= '0;
            cmd_r   <= '0;
            wdata_r <= '0;
        end else if (!sel_lvl) begin
            state_r <= SEE_IDLE;
            cnt_r   <= '0;
        end else if (bit_tick) begin
            case (state_r)
                SEE_IDLE: begin
                    if (din_lvl) begin
                        state_r <= SEE_CMD;
                        cnt_r   <= '0;
                    end
                end
                SEE_CMD: begin
                    cmd_r <= cmd_full;
                    cnt_r <= cnt_r + 1'b1;
                    if (cmd_last) begin
                        cnt_r <= '0;
                        if (opc == OP_READ) begin
                            state_r <= SEE_RDATA;
                        end else if (opc == OP_WRITE
                                     || (opc == OP_EXT && sub == SUB_WRITE_ALL)) begin
                            state_r <= SEE_WDATA;
                        end else begin
                            state_r <= SEE_DONE;
                        end
                    end
                end
                SEE_WDATA: begin
                    wdata_r <= {wdata_r[DATA_W-2:0], din_lvl};
                    cnt_r   <= cnt_r + 1'b1;
                    if (data_last) begin
                        state_r <= SEE_DONE;
                    end
                end
                SEE_RDATA: begin
                    cnt_r <= data_last ? '0 : cnt_r + 1'b1;
                end
                SEE_DONE: begin
                    state_r <= SEE_DONE;
                end
                default: begin
                    state_r <= SEE_IDLE;
                end
            endcase
        end
    end

    // decode launches at the edge that carries the last needed bit
    always_comb begin
        launch      = 1'b0;
        launch_kind = PRG_WORD;
        launch_addr = cmd_full[ADDR_W-1:0];
        launch_data = {wdata_r[DATA_W-2:0], din_lvl};
        if (bit_tick && prog_en_r) begin
            if (state_r == SEE_CMD && cmd_last) begin
                if (opc == OP_ERASE) begin
                    launch      = 1'b1;
                    launch_data = ERASED_WORD;
                end else if (opc == OP_EXT && sub == SUB_ERASE_ALL) begin
                    launch      = 1'b1;
                    launch_kind = PRG_ERALL;
                    launch_data = ERASED_WORD;
                end
            end else if (state_r == SEE_WDATA && data_last) begin
                launch      = 1'b1;
                launch_addr = cmd_r[ADDR_W-1:0];
                launch_kind = (cmd_r[CMD_BITS-1 -: 2] == OP_WRITE) ? PRG_WORD : PRG_WRALL;
            end
        end
    end

    // protection state, power-on disabled
    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            prog_en_r <= 1'b0;
        end else if (bit_tick && state_r == SEE_CMD && cmd_last && opc == OP_EXT) begin
            if (sub == SUB_PROG_EN) begin
                prog_en_r <= 1'b1;
            end else if (sub == SUB_PROG_DIS) begin
                prog_en_r <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // programming request queue; engine drains at its own pace

    localparam int unsigned REQ_W = 2 + ADDR_W + DATA_W;
    logic             req_valid;
    logic [REQ_W-1:0] req_data;
    logic             req_ready;
    logic             q_ready;
    logic             eng_busy_r;

    // launches while busy are dropped, never queued
    seeprm_fifo #(
        .WIDTH (REQ_W),
        .DEPTH (FIFO_DEPTH)
    ) u_req_fifo (
        .i_clk_sys   (i_clk_sys),
        .i_nrst      (i_nrst),
        .i_in_valid  (launch && !o_busy),
        .i_in_data   ({launch_kind, launch_addr, launch_data}),
        .o_in_ready  (q_ready),
        .o_out_valid (req_valid),
        .o_out_data  (req_data),
        .i_out_ready (req_ready)
    );

    assign req_ready = !eng_busy_r;

    ////////////////////////////////////////////////////////////////////
    // self-timed engine, independent of the serial clock

    seeprm_prg_t       eng_kind_r;
    logic [ADDR_W-1:0] eng_addr_r;
    logic [DATA_W-1:0] eng_data_r;
    logic [TMR_W-1:0]  tmr_r;

    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            eng_busy_r <= 1'b0;
            eng_kind_r <= PRG_WORD;
            eng_addr_r <= '0;
            eng_data_r <= '0;
            tmr_r      <= '0;
        end else if (!eng_busy_r) begin
            if (req_valid) begin
                eng_busy_r <= 1'b1;
                eng_kind_r <= seeprm_prg_t'(req_data[REQ_W-1 -: 2]);
                eng_addr_r <= req_data[DATA_W +: ADDR_W];
                eng_data_r <= req_data[DATA_W-1:0];
                case (seeprm_prg_t'(req_data[REQ_W-1 -: 2]))
                    PRG_ERALL: tmr_r <= TMR_W'(ERALL_CYC - 1);
                    PRG_WRALL: tmr_r <= TMR_W'(WRALL_CYC - 1);
                    default:   tmr_r <= TMR_W'(WORD_CYC - 1);
                endcase
            end
        end else if (tmr_r == '0) begin
            eng_busy_r <= 1'b0;
        end else begin
            tmr_r <= tmr_r - 1'b1;
        end
    end

    // array committed at the end of the cycle
    always_ff @(posedge i_clk_sys) begin
        if (eng_busy_r && tmr_r == '0) begin
            for (int i = 0; i < WORDS; i++) begin
                if (eng_kind_r != PRG_WORD || eng_addr_r == ADDR_W'(i)) begin
                    array_r[i] <= eng_data_r;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // output pin

    logic status_arm_r;

    // read shifter: dummy zero at the last address edge, then MSB first
    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            raddr_r  <= '0;
            rshift_r <= '0;
        end else if (bit_tick && state_r == SEE_CMD && cmd_last && opc == OP_READ) begin
            raddr_r  <= cmd_full[ADDR_W-1:0] + 1'b1;
            rshift_r <= array_r[cmd_full[ADDR_W-1:0]];
        end else if (bit_tick && state_r == SEE_RDATA) begin
            if (data_last) begin
                raddr_r  <= raddr_r + 1'b1;
                rshift_r <= array_r[raddr_r];
            end else begin
                rshift_r <= {rshift_r[DATA_W-2:0], 1'b0};
            end
        end
    end

    // status shows only after a deselect that followed a launch
    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            status_arm_r <= 1'b0;
        end else if (launch && !o_busy) begin
            status_arm_r <= 1'b0;
        end else if (!sel_lvl) begin
            status_arm_r <= o_busy || status_arm_r;
        end else if (bit_tick && state_r == SEE_IDLE && din_lvl) begin
            status_arm_r <= 1'b0;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            o_serial_out    <= 1'b0;
            o_serial_out_oe <= 1'b0;
            o_busy          <= 1'b0;
        end else begin
            o_busy <= eng_busy_r || req_valid || (launch && q_ready && !o_busy);
            if (!sel_lvl) begin
                o_serial_out_oe <= 1'b0;
                o_serial_out    <= 1'b0;
            end else if (state_r == SEE_RDATA) begin
                o_serial_out_oe <= 1'b1;
                o_serial_out    <= bit_tick ? rshift_r[DATA_W-1] : o_serial_out;
            end else if (bit_tick && state_r == SEE_CMD && cmd_last && opc == OP_READ) begin
                o_serial_out_oe <= 1'b1;
                o_serial_out    <= 1'b0;
            end else if (status_arm_r && state_r == SEE_IDLE) begin
                o_serial_out_oe <= 1'b1;
                o_serial_out    <= !o_busy;
            end else begin
                o_serial_out_oe <= 1'b0;
            end
        end
    end
endmodule : seeprm_core
`default_nettype wire

// file: core/seeprm_fifo.sv
/*
 * Small flip-flop FIFO with valid/ready on both sides.
 * Assumes one clock; depth a power of two.
 */
`timescale 1ns/10ps
`default_nettype none
module seeprm_fifo #(
    parameter int unsigned WIDTH = 16,
    parameter int unsigned DEPTH = 4
) (
    // clock and reset
    input  wire logic             i_clk_sys,
    input  wire logic             i_nrst,
    // fill side
    input  wire logic             i_in_valid,
    input  wire logic [WIDTH-1:0] i_in_data,
    output logic                  o_in_ready,
    // drain side
    output logic                  o_out_valid,
    output logic [WIDTH-1:0]      o_out_data,
    input  wire logic             i_out_ready
);
    localparam int unsigned AW = $clog2(DEPTH);

    initial begin
        if (DEPTH < 2 || (1 << AW) != DEPTH) begin
            $error("fifo depth must be a power of two, at least 2");
        end
    end

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW:0]      wr_r;
    logic [AW:0]      rd_r;
    logic             push;
    logic             pop;

    assign o_in_ready  = (wr_r - rd_r) != (AW+1)'(DEPTH);
    assign o_out_valid = wr_r != rd_r;
    assign o_out_data  = mem_r[rd_r[AW-1:0]];
    assign push        = i_in_valid && o_in_ready;
    assign pop         = o_out_valid && i_out_ready;

    always_ff @(posedge i_clk_sys) begin
        if (push) begin
            mem_r[wr_r[AW-1:0]] <= i_in_data;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            wr_r <= '0;
            rd_r <= '0;
        end else begin
            if (push) begin
                wr_r <= wr_r + 1'b1;
            end
            if (pop) begin
                rd_r <= rd_r + 1'b1;
            end
        end
    end
endmodule : seeprm_fifo
`default_nettype wire

// file: core/seeprm_sync.sv
/*
 * Three-stage pin synchroniser with agreement filter and edge outputs.
 * Assumes the input is asynchronous to i_clk_sys.
 */
`timescale 1ns/10ps
`default_nettype none
module seeprm_sync (
    // clock and reset
    input  wire logic i_clk_sys,
    input  wire logic i_nrst,
    // pin
    input  wire logic i_pin,
    // filtered level and edges
    output logic      o_level,
    output logic      o_rise,
    output logic      o_fall
);
    logic [2:0] stage_r;

    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            stage_r <= 3'h0;
        end else begin
            stage_r <= {stage_r[1:0], i_pin};
        end
    end

    // level moves only once stages two and three agree
    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            o_level <= 1'b0;
            o_rise  <= 1'b0;
            o_fall  <= 1'b0;
        end else begin
            o_rise  <= 1'b0;
            o_fall  <= 1'b0;
            if (stage_r[1] == stage_r[2] && stage_r[2] != o_level) begin
                o_level <= stage_r[2];
                o_rise  <= stage_r[2];
                o_fall  <= ~stage_r[2];
            end
        end
    end
endmodule : seeprm_sync
`default_nettype wire

// file: testbench/seeprm_bench.sv
/* self-checking bench of seeprm_core driven through the host model.
   assumes shortened programming times. */
`timescale 1ns/10ps
`default_nettype none
module seeprm_bench
    import seeprm_pkg::*;
();
    logic        i_clk_sys = 1'b0;
    logic        i_nrst    = 1'b0;
    wire logic   sel, sclk, din, dout, oe, busy, line;
    int          fail_count = 0;
    int          comparisons = 0;
    logic [15:0] exp_mem [64];
    always #20 i_clk_sys = ~i_clk_sys;
    seeprm_core #(.WORD_CYC(200), .ERALL_CYC(300), .WRALL_CYC(400), .FIFO_DEPTH(4)) i_seeprm_core (
        .i_clk_sys(i_clk_sys), .i_nrst(i_nrst), .i_select(sel), .i_sclk(sclk),
        .i_serial_in(din), .o_serial_out(dout), .o_serial_out_oe(oe), .o_busy(busy));
    seeprm_host i_seeprm_host (.i_clk_sys(i_clk_sys), .i_do(dout), .i_do_oe(oe),
        .o_select(sel), .o_sclk(sclk), .o_din(din), .o_line(line));
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [15:0] seen, input logic [15:0] want);
        comparisons++;
        if (seen !== want) begin
            fail_count++;
            $display("MISMATCH t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask : chk
    task automatic wrap_up;
        $display("comparisons=%0d fail_count=%0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : wrap_up
    task automatic instr(input logic [1:0] op, input logic [5:0] a, input logic [15:0] d);
        if (op == OP_WRITE || (op == OP_EXT && a[5:4] == SUB_WRITE_ALL)) begin
            i_seeprm_host.frame({1'b1, op, a, d}, 25);
        end else begin
            i_seeprm_host.frame({16'h0000, 1'b1, op, a}, 9);
        end
    endtask : instr
    task automatic sub(input logic [1:0] c);
        instr(OP_EXT, {c, 4'h0}, 16'h0000);
        i_seeprm_host.desel();
    endtask : sub
    task automatic status_chk(input logic first);
        i_seeprm_host.desel();
        i_seeprm_host.sel_up();
        repeat (6) @(posedge i_clk_sys);
        @(negedge i_clk_sys);
        chk({15'h0, line}, {15'h0, first});
        for (int n = 0; n < 2000 && line !== 1'b1; n++) @(negedge i_clk_sys);
        chk({15'h0, line}, 16'h0001);
        chk({15'h0, busy}, 16'h0000);
        i_seeprm_host.desel();
    endtask : status_chk
    task automatic read_chk(input logic [5:0] a, input int n);
        logic        s;
        logic [15:0] w;
        instr(OP_READ, a, 16'h0000);
        for (int e = 0; e <= 16 * n; e++) begin
            i_seeprm_host.bit_io(1'b0, s);
            if (e == 0) chk({15'h0, s}, 16'h0000);
            else w = {w[14:0], s};
            if (e > 0 && e % 16 == 0) chk(w, exp_mem[6'(a + e / 16 - 1)]);
        end
        i_seeprm_host.desel();
        @(negedge i_clk_sys);
        chk({15'h0, oe}, 16'h0000);
    endtask : read_chk
    task automatic quiet_chk;
        i_seeprm_host.desel();
        repeat (20) @(posedge i_clk_sys);
        @(negedge i_clk_sys);
        chk({15'h0, busy}, 16'h0000);
    endtask : quiet_chk
    ////////////////////////////////////////////////////////////////////////////
    task automatic t_erase_all;
        sub(SUB_PROG_EN);
        instr(OP_EXT, {SUB_ERASE_ALL, 4'h0}, 16'h0000);
        status_chk(1'b0);
        foreach (exp_mem[i]) exp_mem[i] = ERASED_WORD;
        read_chk(6'h14, 1);
    endtask : t_erase_all
    task automatic t_write;
        logic [24:0] v;
        v = {1'b1, OP_WRITE, 6'h3F, 16'hA55A};
        i_seeprm_host.frame(25'h0, 4);
        i_seeprm_host.frame(v >> 15, 10);
        repeat (30) @(posedge i_clk_sys); // clock paused high
        i_seeprm_host.frame(v, 15);
        status_chk(1'b0);
        instr(OP_WRITE, 6'h00, 16'h0F1E);
        status_chk(1'b0);
        instr(OP_WRITE, 6'h05, 16'hBEEF);
        i_seeprm_host.frame({16'h0000, 1'b1, OP_ERASE, 6'h05}, 9);
        status_chk(1'b0);
        exp_mem[63] = 16'hA55A;
        exp_mem[0]  = 16'h0F1E;
        exp_mem[5]  = 16'hBEEF;
        read_chk(6'h3F, 2);
        read_chk(6'h05, 1);
    endtask : t_write
    task automatic t_erase_quiet;
        logic seen = 1'b0;
        instr(OP_ERASE, 6'h05, 16'h0000);
        i_seeprm_host.desel();
        for (int n = 0; n < 2000 && (n < 20 || busy !== 1'b0); n++) begin
            @(negedge i_clk_sys);
            seen = seen | oe;
        end
        chk({15'h0, seen}, 16'h0000);
        status_chk(1'b1);
        exp_mem[5] = ERASED_WORD;
        read_chk(6'h05, 1);
    endtask : t_erase_quiet
    task automatic t_guard;
        i_seeprm_host.frame({1'b1, OP_WRITE, 6'h00, 16'h0000} >> 5, 20);
        quiet_chk();
        sub(SUB_PROG_DIS);
        instr(OP_WRITE, 6'h00, 16'h1111);
        quiet_chk();
        read_chk(6'h00, 1);
    endtask : t_guard
    task automatic t_write_all;
        sub(SUB_PROG_EN);
        instr(OP_EXT, {SUB_WRITE_ALL, 4'h0}, 16'h3C96);
        status_chk(1'b0);
        foreach (exp_mem[i]) exp_mem[i] = 16'h3C96;
        read_chk(6'h28, 1);
    endtask : t_write_all
    initial begin
        repeat (10) @(posedge i_clk_sys);
        i_nrst <= 1'b1;
        @(negedge i_clk_sys);
        chk({14'h0, oe, busy}, 16'h0000);
        instr(OP_WRITE, 6'h05, 16'h1234);
        quiet_chk();
        t_erase_all();
        t_write();
        t_erase_quiet();
        t_guard();
        t_write_all();
        wrap_up();
    end
    initial begin
        repeat (40000) @(posedge i_clk_sys);
        fail_count++;
        wrap_up();
    end
endmodule : seeprm_bench
`default_nettype wire

// file: testbench/seeprm_host.sv
/* host model: drives select, clock and serial_in; resolves the data line.
   assumes the bench calls its tasks; clock toggles every 4 system cycles. */
`timescale 1ns/10ps
`default_nettype none
module seeprm_host (
    // clock
    input  wire logic i_clk_sys,
    // device output
    input  wire logic i_do,
    input  wire logic i_do_oe,
    // link
    output logic      o_select,
    output logic      o_sclk,
    output logic      o_din,
    output logic      o_line
);
    logic last_r = 1'b0;
    initial begin
        o_select = 1'b0;
        o_sclk   = 1'b0;
        o_din    = 1'b0;
    end
    // no pull on the line: released, it shows the inverse of its last value
    assign o_line = i_do_oe ? i_do : ~last_r;
    always @(posedge i_clk_sys) begin
        if (i_do_oe) begin
            last_r <= i_do;
        end
    end
    task automatic sel_up;
        @(posedge i_clk_sys);
        o_select <= 1'b1;
        repeat (2) @(posedge i_clk_sys);
    endtask : sel_up
    task automatic desel;
        @(posedge i_clk_sys);
        o_select <= 1'b0;
        o_sclk   <= 1'b0;
        repeat (8) @(posedge i_clk_sys); // 320 ns low between instructions
    endtask : desel
    // s is the line just before the rise, i.e. after the previous rise
    task automatic bit_io(input logic b, output logic s);
        @(posedge i_clk_sys);
        o_din  <= b;
        o_sclk <= 1'b0;
        repeat (3) @(posedge i_clk_sys);
        @(negedge i_clk_sys);
        s = o_line;
        @(posedge i_clk_sys);
        o_sclk <= 1'b1; // serial_in taken on this rise
        repeat (3) @(posedge i_clk_sys);
    endtask : bit_io
    task automatic frame(input logic [24:0] v, input int n);
        logic s;
        sel_up();
        for (int i = n - 1; i >= 0; i--) begin
            bit_io(v[i], s);
        end
    endtask : frame
endmodule : seeprm_host
`default_nettype wire

// file: testbench/seeprm_properties.sv
/* port checks of the serial memory front end.
   bound to seeprm_core; one clock domain. */
`timescale 1ns/10ps
`default_nettype none
module seeprm_properties #(
    parameter int unsigned WORD_CYC  = 20,
    parameter int unsigned ERALL_CYC = 40,
    parameter int unsigned WRALL_CYC = 60
) (
    // clock and reset
    input  wire logic i_clk_sys,
    input  wire logic i_nrst,
    // link pins
    input  wire logic i_select,
    input  wire logic i_sclk,
    input  wire logic i_serial_in,
    input  wire logic o_serial_out,
    input  wire logic o_serial_out_oe,
    input  wire logic o_busy
);
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_nrst);
    logic        sclk_q_r;
    logic [3:0]  sclk_age_r;
    logic [3:0]  sel_low_r;
    int unsigned busy_len_r;
    // ages saturate so that long idle spans stay bounded
    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            sclk_q_r   <= 1'b0;
            sclk_age_r <= 4'hF;
            sel_low_r  <= 4'hF;
            busy_len_r <= 0;
        end else begin
            sclk_q_r   <= i_sclk;
            sclk_age_r <= (i_sclk && !sclk_q_r) ? 4'h0 : sclk_age_r + {3'h0, sclk_age_r != 4'hF};
            sel_low_r  <= i_select ? 4'h0 : sel_low_r + {3'h0, sel_low_r != 4'hF};
            busy_len_r <= o_busy ? busy_len_r + 1 : 0;
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    property p_release; !i_select [*6] |=> !o_serial_out_oe; endproperty
    a_release: assert property (p_release) else $error("output kept on while deselected");
    property p_status; $rose(o_serial_out_oe) && o_busy |-> !o_serial_out; endproperty
    a_status: assert property (p_status) else $error("busy status not low");
    property p_hold; $rose(o_busy) |=> o_busy [*8]; endproperty
    a_hold: assert property (p_hold) else $error("programming cut short");
    property p_bound; busy_len_r <= WORD_CYC + ERALL_CYC + WRALL_CYC + 16; endproperty
    a_bound: assert property (p_bound) else $error("programming never ends");
    property p_launch; $rose(o_busy) |-> sclk_age_r <= 4'hC; endproperty
    a_launch: assert property (p_launch) else $error("busy without a clock edge");
    property p_sel; $rose(o_busy) |-> sel_low_r <= 4'hA; endproperty
    a_sel: assert property (p_sel) else $error("busy while deselected");
    property p_edge;
        $changed(o_serial_out) && o_serial_out_oe && $past(o_serial_out_oe) && !o_busy
            && !$past(o_busy) && !$past(o_busy, 2) && !$past(o_busy, 3) |-> sclk_age_r <= 4'h8;
    endproperty
    a_edge: assert property (p_edge) else $error("output moved without clock");
    property p_dummy;
        $rose(o_serial_out_oe) && !o_serial_out && !o_busy && !$past(o_busy) |-> sclk_age_r <= 4'h8;
    endproperty
    a_dummy: assert property (p_dummy) else $error("dummy bit without edge");
endmodule : seeprm_properties
bind seeprm_core seeprm_properties #(
    .WORD_CYC(WORD_CYC), .ERALL_CYC(ERALL_CYC), .WRALL_CYC(WRALL_CYC)
) i_seeprm_properties (
    .i_clk_sys(i_clk_sys), .i_nrst(i_nrst), .i_select(i_select), .i_sclk(i_sclk),
    .i_serial_in(i_serial_in), .o_serial_out(o_serial_out),
    .o_serial_out_oe(o_serial_out_oe), .o_busy(o_busy)
);
`default_nettype wire
